// *** hdl/dual_watchdog_supervisor.sv ***
// two independent watchdog timers with their configuration and fault registers
// Operation
// (RQ1) two timers, select registers at 3c, 3e
// (RQ2) duration registers at 3d and 3f
// (RQ3) expiry asserts any chosen output set
// (RQ4) clear by input, output, or both
// (RQ5) select bits 1:0 pick general input
// (RQ6) select bits 4:2 pick programmable output
// (RQ7) dependency 00 or 11 needs both
// (RQ8) 01 output only, 10 input only
// (RQ9) select bit 7 enables initial period
// (RQ10) each timer keeps own periods
// (RQ11) initial period after reset and enable
// (RQ12) processor pulses clear within each period
// (RQ13) register 62 reports faults, inputs, reset
// (RQ14) period codes 6.25 ms times four steps
// (RQ15) duration bit 6 enables the timer
// (RQ16) normal period after initial one passed
// (RQ17) fault read clears; first read invalid
// (RQ18) expiry flags fault, asserts, restarts initial
// (RQ19) qualifying clear restarts running period
`timescale 1ns/10ps
module dual_watchdog_supervisor import wdog_pkg::*; #(
  parameter int unsigned BASE_CYCLES = BASE_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register bank port from the serial front end
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // monitored pins and output states
  input wire logic [3:0] general_input_i,
  input wire logic [7:0] programmable_output_i,
  input wire logic manual_reset_input_i,
  // per-timer choice of outputs to assert on expiry
  input wire logic [7:0] watchdog_one_out_map_i,
  input wire logic [7:0] watchdog_two_out_map_i,
  // expiry results
  output logic [1:0] watchdog_trip_o,
  output logic [7:0] programmable_output_assert_o
);

  logic [7:0] sel_reg [2];
  logic [7:0] dur_reg [2];
  logic [7:0] fault_reg;
  logic [7:0] fault_next;
  logic first_read_reg;
  logic [7:0] rdata_reg;
  logic [1:0] trip_reg;
  logic [7:0] assert_reg;
  logic [3:0] gpi_q_reg;
  logic [7:0] po_q_reg;

  // address decode of the configuration bank
  wire sel_wr [2];
  wire dur_wr [2];
  assign sel_wr[0] = reg_wr_i && (reg_addr_i == WD1_SEL_ADDR); // [RQ1]
  assign sel_wr[1] = reg_wr_i && (reg_addr_i == WD2_SEL_ADDR); // [RQ1]
  assign dur_wr[0] = reg_wr_i && (reg_addr_i == WD1_DUR_ADDR); // [RQ2]
  assign dur_wr[1] = reg_wr_i && (reg_addr_i == WD2_DUR_ADDR); // [RQ2]
  wire fault_rd = reg_rd_i && (reg_addr_i == FAULT_ADDR);

  // read mux; unmapped offsets read as zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      WD1_SEL_ADDR: rd_mux = sel_reg[0];
      WD1_DUR_ADDR: rd_mux = dur_reg[0];
      WD2_SEL_ADDR: rd_mux = sel_reg[1];
      WD2_DUR_ADDR: rd_mux = dur_reg[1];
      FAULT_ADDR: rd_mux = first_read_reg ? fault_reg : 8'h00; // [RQ17]
      default: rd_mux = 8'h00;
    endcase
  end

  // configuration registers; written bytes take effect at once
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_i) begin
        sel_reg[i] <= SEL_RESET;
        dur_reg[i] <= DUR_RESET;
      end else begin
        if (sel_wr[i]) begin
          sel_reg[i] <= reg_wdata_i;
        end
        if (dur_wr[i]) begin
          dur_reg[i] <= reg_wdata_i & 8'h7f; // bit 7 unused [RQ15]
        end
      end
    end
  end

  // read data register and the first-read marker
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
      first_read_reg <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        rdata_reg <= rd_mux;
      end
      if (fault_rd) begin
        first_read_reg <= 1'b1; // first fault read returns invalid zero [RQ17]
      end
    end
  end
  assign reg_rdata_o = rdata_reg;

  // edge history for activity detection
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gpi_q_reg <= 4'h0;
      po_q_reg <= 8'h00;
    end else begin
      gpi_q_reg <= general_input_i;
      po_q_reg <= programmable_output_i;
    end
  end
  wire [3:0] gpi_rise = general_input_i & ~gpi_q_reg;
  wire [7:0] po_rise = programmable_output_i & ~po_q_reg;

  logic [1:0] expire;
  logic [3:0] gpi_fault_set [2];

  // one timer per channel, sharing no state
  for (genvar ch = 0; ch < 2; ch++) begin : g_wd
    phase_t phase_reg;
    phase_t phase_next;
    logic en_q_reg;
    logic seen_gpi_reg;
    logic seen_po_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [TICK_W-1:0] tick_reg;

    wire [1:0] gpi_idx = sel_reg[ch][SEL_GPI_LSB +: 2]; // [RQ5]
    wire [2:0] po_idx = sel_reg[ch][SEL_PO_LSB +: 3]; // [RQ6]
    wire [1:0] dep = sel_reg[ch][SEL_DEP_LSB +: 2];
    wire init_en = sel_reg[ch][SEL_INIT_EN_BIT]; // [RQ9]
    wire en = dur_reg[ch][DUR_EN_BIT]; // [RQ15]
    wire gpi_evt = gpi_rise[gpi_idx]; // [RQ4]
    wire po_evt = po_rise[po_idx]; // [RQ4]
    wire gpi_ok = gpi_evt || seen_gpi_reg;
    wire po_ok = po_evt || seen_po_reg;
    // a pulse on one source is remembered until its partner arrives
    wire clear_ok = (dep == DEP_PO_ONLY) ? po_ok : // [RQ8]
                    (dep == DEP_GPI_ONLY) ? gpi_ok : // [RQ8]
                    (gpi_ok && po_ok); // [RQ7]
    // period code for the running phase, own fields per timer
    wire [2:0] code = (phase_reg == PH_INITIAL) ? dur_reg[ch][DUR_INIT_LSB +: 3] :
                      dur_reg[ch][DUR_NORM_LSB +: 3]; // [RQ10] [RQ16]
    // period is base times four to the power of the code
    wire [TICK_W-1:0] last_tick = TICK_W'((32'd1 << {code, 1'b0}) - 32'd1); // [RQ14]
    wire pre_end = (pre_reg == PRE_W'(BASE_CYCLES - 1));
    wire running = (phase_reg != PH_OFF);
    wire start = en && (!en_q_reg || !running);
    assign expire[ch] = running && en && en_q_reg && pre_end && (tick_reg == last_tick);
    wire start_phase_init = init_en;

    // phase selection
    always_comb begin
      phase_next = phase_reg;
      if (!en) begin
        phase_next = PH_OFF;
      end else if (start || expire[ch]) begin
        phase_next = start_phase_init ? PH_INITIAL : PH_NORMAL; // [RQ11] [RQ18]
      end else if (clear_ok) begin
        phase_next = PH_NORMAL; // [RQ16]
      end
    end

    // counters and seen flags restart on start, expiry or a qualifying clear
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        phase_reg <= PH_OFF;
        en_q_reg <= 1'b0;
        seen_gpi_reg <= 1'b0;
        seen_po_reg <= 1'b0;
        pre_reg <= '0;
        tick_reg <= '0;
      end else begin
        phase_reg <= phase_next;
        en_q_reg <= en;
        if (!en || start || expire[ch] || clear_ok) begin
          pre_reg <= '0; // [RQ19]
          tick_reg <= '0;
          seen_gpi_reg <= 1'b0;
          seen_po_reg <= 1'b0;
        end else begin
          pre_reg <= pre_end ? '0 : pre_reg + PRE_W'(1);
          tick_reg <= pre_end ? tick_reg + TICK_W'(1) : tick_reg;
          seen_gpi_reg <= gpi_ok;
          seen_po_reg <= po_ok;
        end
      end
    end

    // input bit logged too when the timer watches a general input
    assign gpi_fault_set[ch] = (expire[ch] && dep != DEP_PO_ONLY) ?
                               (4'h1 << gpi_idx) : 4'h0;
  end

  // fault flags; a new event wins over the clearing read
  always_comb begin
    fault_next = fault_rd ? 8'h00 : fault_reg; // [RQ17]
    fault_next[FLT_WD_LSB +: 2] = fault_next[FLT_WD_LSB +: 2] | expire; // [RQ18]
    fault_next[FLT_GPI_LSB +: 4] = fault_next[FLT_GPI_LSB +: 4] | general_input_i
                                   | gpi_fault_set[0] | gpi_fault_set[1]; // [RQ13]
    fault_next[FLT_MR_BIT] = fault_next[FLT_MR_BIT] | manual_reset_input_i; // [RQ13]
    fault_next[7] = 1'b0;
  end

  // expiry pulses and the outputs they assert
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fault_reg <= FAULT_RESET;
      trip_reg <= 2'b00;
      assert_reg <= 8'h00;
    end else begin
      fault_reg <= fault_next;
      trip_reg <= expire; // [RQ18]
      assert_reg <= ({8{expire[0]}} & watchdog_one_out_map_i)
                  | ({8{expire[1]}} & watchdog_two_out_map_i); // [RQ3]
    end
  end
  assign watchdog_trip_o = trip_reg;
  assign programmable_output_assert_o = assert_reg;

endmodule

// *** hdl/wdog_pkg.sv ***
// constants shared by the dual watchdog supervisor
package wdog_pkg;
  // register offsets in the configuration bank
  localparam logic [7:0] WD1_SEL_ADDR = 8'h3c;
  localparam logic [7:0] WD1_DUR_ADDR = 8'h3d;
  localparam logic [7:0] WD2_SEL_ADDR = 8'h3e;
  localparam logic [7:0] WD2_DUR_ADDR = 8'h3f;
  localparam logic [7:0] FAULT_ADDR = 8'h62;
  // values after reset (configuration shadow empty, both timers off)
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] DUR_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  // clear-source select field layout
  localparam int SEL_GPI_LSB = 0;
  localparam int SEL_PO_LSB = 2;
  localparam int SEL_DEP_LSB = 5;
  localparam int SEL_INIT_EN_BIT = 7;
  // duration field layout
  localparam int DUR_NORM_LSB = 0;
  localparam int DUR_INIT_LSB = 3;
  localparam int DUR_EN_BIT = 6;
  // fault register layout
  localparam int FLT_WD_LSB = 0;
  localparam int FLT_GPI_LSB = 2;
  localparam int FLT_MR_BIT = 6;
  // dependency codes
  localparam logic [1:0] DEP_PO_ONLY = 2'b01;
  localparam logic [1:0] DEP_GPI_ONLY = 2'b10;
  // timing: shortest period 6.25 ms, each code step is four times longer
  localparam int CLK_PERIOD_PS = 25000;
  localparam longint BASE_PERIOD_PS = 64'd6250000000;
  localparam int BASE_TICK_CYCLES = int'(BASE_PERIOD_PS / CLK_PERIOD_PS);
  localparam int TICK_W = 15;
  localparam int PRE_W = 32;
  // timer phase
  typedef enum logic [1:0] {PH_OFF, PH_INITIAL, PH_NORMAL} phase_t;
endpackage

// *** bench/dual_watchdog_supervisor_props.sv ***
// assertion checker for the watchdog supervisor ports
`timescale 1ns/10ps
module wdog_props import wdog_pkg::*; #(parameter int unsigned BASE_CYCLES = 4) (
  // clock, reset, register port
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins, maps, results
  input wire logic [3:0] general_input_i,
  input wire logic [7:0] programmable_output_i,
  input wire logic manual_reset_input_i,
  input wire logic [7:0] watchdog_one_out_map_i,
  input wire logic [7:0] watchdog_two_out_map_i,
  input wire logic [1:0] watchdog_trip_o,
  input wire logic [7:0] programmable_output_assert_o
);
  // strobes decoded once for the properties
  wire logic rd_flt = reg_rd_i && reg_addr_i == FAULT_ADDR;
  wire logic rd_sel = reg_rd_i && reg_addr_i == WD1_SEL_ADDR;
  wire logic rd_dur = reg_rd_i && reg_addr_i inside {WD1_DUR_ADDR, WD2_DUR_ADDR};
  // first fault read after reset returns invalid data, so it proves nothing
  logic flt_read_reg;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flt_read_reg <= 1'b0;
    end else if (rd_flt) begin
      flt_read_reg <= 1'b1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_trip_pulse; watchdog_trip_o[0] |=> !watchdog_trip_o[0]; endproperty
  a_trip_pulse: assert property (p_trip_pulse) else $error("long trip");
  property p_out_map; programmable_output_assert_o == ({8{watchdog_trip_o[0]}} &
    $past(watchdog_one_out_map_i) | {8{watchdog_trip_o[1]}} & $past(watchdog_two_out_map_i));
  endproperty
  a_out_map: assert property (p_out_map) else $error("bad output set");
  property p_unmapped; reg_rd_i && reg_addr_i[7:2] != 6'h0f && !rd_flt |=> reg_rdata_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_dur_bit7; rd_dur |=> !reg_rdata_o[7]; endproperty
  a_dur_bit7: assert property (p_dur_bit7) else $error("unused bit set");
  property p_flt_bit7; rd_flt |=> !reg_rdata_o[7]; endproperty
  a_flt_bit7: assert property (p_flt_bit7) else $error("fault bit7 set");
  property p_sel_rw; reg_wr_i && reg_addr_i == WD1_SEL_ADDR ##2 rd_sel |=>
    reg_rdata_o == $past(reg_wdata_i, 3); endproperty
  a_sel_rw: assert property (p_sel_rw) else $error("select lost");
  property p_mr_flag; manual_reset_input_i ##1 rd_flt && flt_read_reg |=>
    reg_rdata_o[FLT_MR_BIT]; endproperty
  a_mr_flag: assert property (p_mr_flag) else $error("reset flag lost");
  property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // main scenarios reached
  c_trip_one: cover property (watchdog_trip_o[0]);
  c_trip_two: cover property (watchdog_trip_o[1]);
  c_flt_seen: cover property (rd_flt ##1 reg_rdata_o[1]);
endmodule
bind dual_watchdog_supervisor wdog_props #(.BASE_CYCLES(BASE_CYCLES)) u_props (.*);

// *** bench/wdog_cpu_model.sv ***
// processor model pulsing a watchdog clear line
`timescale 1ns/10ps
module wdog_cpu_model (
  // clock and pacing
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic [7:0] gap_i,
  // clear pulse
  output logic pulse_o
);
  logic [7:0] cnt_reg = 8'h00;
  // one pulse per gap_i+1 cycles; a long gap misses the period
  always @(negedge core_clk_i) begin
    cnt_reg <= (!run_i || cnt_reg == gap_i) ? 8'h00 : cnt_reg + 8'h01;
    pulse_o <= run_i && cnt_reg == gap_i;
  end
endmodule

// *** bench/dual_watchdog_supervisor_tb_top.sv ***
// self-checking bench for the dual watchdog supervisor
`timescale 1ns/10ps
module dual_watchdog_supervisor_tb_top import wdog_pkg::*;;
  typedef struct packed {logic [7:0] a, d, e;} row_t;
  typedef struct packed {logic [1:0] dep; logic g, p, x; logic [7:0] gap;} dep_t;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, mr = 1'h0, run = 1'h0, pulse;
  logic gon = 1'h0, pon = 1'h0;
  logic [1:0] gs = 2'h0, trip;
  logic [2:0] ps = 3'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, gap = 8'h0a, rdata, pa, rd_v;
  logic [7:0] pa_or = 8'h00;
  int errors = 0, comparisons = 0, cyc = 0, n1 = 0, last2 = 0, gap2 = 0;
  row_t rows [6] = '{'{WD1_SEL_ADDR, 8'ha5, 8'ha5}, '{WD1_DUR_ADDR, 8'hbf, 8'h3f},
    '{WD2_SEL_ADDR, 8'h5a, 8'h5a}, '{WD2_DUR_ADDR, 8'h89, 8'h09},
    '{8'h40, 8'h77, 8'h00}, '{FAULT_ADDR, 8'hff, 8'h00}};
  // last row has a slow processor: clear arrives after the normal period
  dep_t drow [7] = '{'{2'h0, 1'h1, 1'h1, 1'h0, 8'h0a}, '{2'h1, 1'h0, 1'h1, 1'h0, 8'h0a},
    '{2'h2, 1'h1, 1'h0, 1'h0, 8'h0a}, '{2'h3, 1'h1, 1'h1, 1'h0, 8'h0a},
    '{2'h3, 1'h0, 1'h1, 1'h1, 8'h0a}, '{2'h1, 1'h1, 1'h0, 1'h1, 8'h0a},
    '{2'h2, 1'h1, 1'h0, 1'h1, 8'h28}};
  // processor pulse routed to the selected input and output
  wire logic [3:0] gi = gon ? 4'(pulse) << gs : 4'h0;
  wire logic [7:0] po = pon ? 8'(pulse) << ps : 8'h00;
  dual_watchdog_supervisor #(.BASE_CYCLES(4)) dut (.core_clk_i(clk), .reset_i(rst),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .general_input_i(gi), .programmable_output_i(po), .manual_reset_input_i(mr),
    .watchdog_one_out_map_i(8'h81), .watchdog_two_out_map_i(8'h3c),
    .watchdog_trip_o(trip), .programmable_output_assert_o(pa));
  wdog_cpu_model cpu (.core_clk_i(clk), .run_i(run), .gap_i(gap), .pulse_o(pulse));
  initial forever #12.5 clk = ~clk;
  // trips counted on the falling edge, clear of the design's updates
  always @(negedge clk) begin
    cyc++;
    pa_or = pa_or | pa;
    if (trip[0]) n1++;
    if (trip[1]) gap2 = cyc - last2;
    if (trip[1]) last2 = cyc;
  end
  task automatic check(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes held for one edge, then one idle edge before the next access
  task automatic wreg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk) wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr = a;
    rd = 1'h1;
    @(negedge clk) rd = 1'h0;
    @(negedge clk) rd_v = rdata;
  endtask
  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    errors++;
    results();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'h0;
    foreach (rows[j]) begin
      wreg(rows[j].a, rows[j].d);
      rreg(rows[j].a);
      check(rd_v, rows[j].e);
    end
    rst = 1'h1;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    foreach (rows[j]) begin
      rreg(rows[j].a);
      check(rd_v, 8'h00);
    end
    $display("registers and reset done");
    foreach (drow[i]) begin
      gs = 2'(i);
      ps = 3'(i + 3);
      gon = drow[i].g;
      pon = drow[i].p;
      gap = drow[i].gap;
      run = 1'h1;
      wreg(WD1_SEL_ADDR, {1'h1, drow[i].dep, ps, gs});
      n1 = 0;
      wreg(WD1_DUR_ADDR, 8'h51);
      repeat (200) @(negedge clk);
      run = 1'h0;
      wreg(WD1_DUR_ADDR, 8'h00);
      check(8'(n1 != 0), 8'(drow[i].x));
    end
    check(pa_or, 8'h81);
    $display("clear sources done");
    // with the initial period on, each start and expiry restarts in it; off, the normal one
    for (int k = 0; k < 2; k++) begin
      n1 = 0;
      wreg(WD2_SEL_ADDR, k ? 8'h00 : 8'h80);
      wreg(WD2_DUR_ADDR, 8'h48);
      repeat (60) @(negedge clk);
      wreg(WD2_DUR_ADDR, 8'h00);
      check(8'(gap2), k ? 8'h04 : 8'h10);
      check(8'(n1), 8'h00);
    end
    check(pa_or, 8'hbd);
    rreg(FAULT_ADDR);
    check(rd_v, 8'h3f);
    mr = 1'h1;
    @(negedge clk) mr = 1'h0;
    rreg(FAULT_ADDR);
    check(rd_v, 8'h40);
    rreg(FAULT_ADDR);
    check(rd_v, 8'h00);
    $display("periods and faults done");
    results();
  end
endmodule
